// >>> rtl/gpio_lcd_regs.vh
// register offsets, field positions, reset values and pin group layout
// for the lcd shared pin ports; included by every design file of the block
`ifndef GPIO_LCD_REGS_VH
`define GPIO_LCD_REGS_VH

// ***************************************************************
// register offsets on the core register port
// ***************************************************************
`define ADDR_W 9
`define OFS_PORT_B_PINS 9'h006
`define OFS_SERIAL_SHARED_PORT 9'h007
`define OFS_LCD_SHARED_BIDIR_PORT 9'h008
`define OFS_LCD_SHARED_INPUT_PORT 9'h009
`define OFS_CORE_OPTIONS 9'h081
`define OFS_PORT_B_DIRECTION 9'h086
`define OFS_SERIAL_SHARED_PORT_DIRECTION 9'h087
`define OFS_LCD_SHARED_BIDIR_DIRECTION 9'h088
`define OFS_LCD_SHARED_INPUT_DIRECTION 9'h089
`define OFS_LCD_SEGMENT_ENABLE 9'h10D

// ***************************************************************
// reset values
// ***************************************************************
`define RST_CORE_OPTIONS 8'hFF
`define RST_LCD_SEGMENT_ENABLE 8'hFF
`define RST_LATCH 8'h00
// direction reset per bank, bank 0 in the low byte: b, c, d, e
`define RST_DIRECTIONS 32'hFFFF3FFF
// banks whose output latch survives a non power-on reset
`define KEEP_LATCH_ON_SOFT 4'h3

// ***************************************************************
// field positions
// ***************************************************************
`define BIT_PULLUP_DISABLE_N 7
`define SERIAL_PORT_MASK 8'h3F
// lcd_segment_enable groups
`define SEG_ENABLE_LOWER_GROUP 0
`define SEG_ENABLE_E_LOW 1
`define SEG_ENABLE_E_MID 2
`define SEG_ENABLE_E_TOP 6
`define SEG_ENABLE_UPPER_GROUP 7

// ***************************************************************
// bank numbering inside the latch array
// ***************************************************************
`define BANK_B 0
`define BANK_C 1
`define BANK_D 2
`define BANK_E 3
`define BANK_COUNT 4

`endif

// >>> rtl/port_latch_bank.v
// output latch and direction register of one eight bit pin bank
// assumes single cycle write strobes from the register decoder in the top
`include "gpio_lcd_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module port_latch_bank #(
    parameter [7:0] DIR_RESET = 8'hFF,
    parameter KEEP_ON_SOFT = 1
) (
    // clock and resets
    input wire clk,
    input wire sys_rst,
    input wire soft_rst,
    // write side
    input wire wr_latch,
    input wire wr_dir,
    input wire [7:0] wr_data,
    // stored state
    output reg [7:0] latch,
    output reg [7:0] direction
);

    // ***************************************************************
    // output latch
    // ***************************************************************
    // written whatever the direction, so a pin turned to output later
    // shows the last value software wrote
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            latch <= `RST_LATCH;
        end else if (soft_rst) begin
            // some banks keep their latch across a soft reset
            if (KEEP_ON_SOFT == 0) begin
                latch <= `RST_LATCH;
            end
        end else if (wr_latch) begin
            latch <= wr_data;
        end
    end

    // ***************************************************************
    // direction register
    // ***************************************************************
    // every reset returns all pins of the bank to input
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            direction <= DIR_RESET;
        end else if (soft_rst) begin
            direction <= DIR_RESET;
        end else if (wr_dir) begin
            direction <= wr_data;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/gpio_ports_lcd_shared.v
// digital pin ports sharing pins with timer, capture, serial and lcd units
// assumes register strobes synchronous to clk and pins already synchronous
`include "gpio_lcd_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - six bit port direction chosen per pin
// - enabled peripheral overrides the pin direction
// - bit0 general, oscillator out or clock in
// - bit2 general or capture compare pwm
// - bit3 carries serial clock, spi and i2c
// - bit4 spi in or i2c data, bit5 out
// - upper bits 7 and 6 read zero
// - lcd port: five bidir, three input pins
// - direction acts on pins 0-4 digital only
// - pins 5-7 segments 29-31 or commons 3-1
// - power-on reset selects lcd segment drivers
// - set segment enable bit forces lcd use
// - second lcd port is input only
// - set direction tristates, clear drives latch
module gpio_ports_lcd_shared (
    // clock and resets
    input wire clk,
    input wire sys_rst,
    input wire soft_rst,
    // register port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // general port pins
    input wire [7:0] pin_b_in,
    output wire [7:0] pin_b_out,
    output wire [7:0] pin_b_oe,
    output wire [7:0] pullup_on,
    // serial shared port pins
    input wire [5:0] pin_c_in,
    output wire [5:0] pin_c_out,
    output wire [5:0] pin_c_oe,
    // secondary timer and oscillator
    input wire secondary_osc_enable,
    input wire secondary_osc_out,
    input wire secondary_timer_ext_clk_enable,
    output wire secondary_timer_clk_in,
    output wire secondary_osc_in,
    // capture compare pwm unit
    input wire ccp_enable,
    input wire ccp_output_mode,
    input wire capture_compare_pwm_pin,
    output wire capture_in,
    // synchronous serial unit
    input wire serial_enable,
    input wire serial_i2c_mode,
    input wire serial_clk_master,
    input wire serial_clk_out,
    input wire serial_data_out,
    input wire i2c_scl_drive_low,
    input wire i2c_sda_drive_low,
    output wire serial_clk_in,
    output wire serial_data_in,
    // lcd shared bidirectional port pins
    input wire [7:0] pin_d_in,
    output wire [4:0] pin_d_out,
    output wire [4:0] pin_d_oe,
    // lcd shared input port pins
    input wire [7:0] pin_e_in,
    // pin owner towards the lcd driver, high means lcd driver
    output wire [7:0] lcd_mode_d,
    output wire [7:0] lcd_mode_e,
    output wire lcd_common_driver_one
);

    // ***************************************************************
    // register decode
    // ***************************************************************
    wire [`BANK_COUNT-1:0] wr_latch; // per bank latch write strobe
    wire [`BANK_COUNT-1:0] wr_dir; // per bank direction write strobe
    wire [8*`BANK_COUNT-1:0] latch_all; // all latches, bank 0 low
    wire [8*`BANK_COUNT-1:0] dir_all; // all directions, bank 0 low
    wire wr_options;
    wire wr_seg_enable;

    assign wr_latch[`BANK_B] = reg_wr && (reg_addr == `OFS_PORT_B_PINS);
    assign wr_latch[`BANK_C] = reg_wr && (reg_addr == `OFS_SERIAL_SHARED_PORT);
    assign wr_latch[`BANK_D] = reg_wr && (reg_addr == `OFS_LCD_SHARED_BIDIR_PORT);
    assign wr_latch[`BANK_E] = reg_wr && (reg_addr == `OFS_LCD_SHARED_INPUT_PORT);
    assign wr_dir[`BANK_B] = reg_wr && (reg_addr == `OFS_PORT_B_DIRECTION);
    assign wr_dir[`BANK_C] = reg_wr && (reg_addr == `OFS_SERIAL_SHARED_PORT_DIRECTION);
    assign wr_dir[`BANK_D] = reg_wr && (reg_addr == `OFS_LCD_SHARED_BIDIR_DIRECTION);
    assign wr_dir[`BANK_E] = reg_wr && (reg_addr == `OFS_LCD_SHARED_INPUT_DIRECTION);
    assign wr_options = reg_wr && (reg_addr == `OFS_CORE_OPTIONS);
    assign wr_seg_enable = reg_wr && (reg_addr == `OFS_LCD_SEGMENT_ENABLE);

    // ***************************************************************
    // latch and direction banks
    // ***************************************************************
    // one bank per port; the six bit port masks its upper bits on
    // write so they can never be seen
    genvar g;
    generate
        for (g = 0; g < `BANK_COUNT; g = g + 1) begin : bank
            wire [7:0] bank_wdata;
            localparam [31:0] DIR_RESETS = `RST_DIRECTIONS; // one reset byte per bank
            assign bank_wdata = (g == `BANK_C) ? (reg_wdata & `SERIAL_PORT_MASK)
                                               : reg_wdata;
            port_latch_bank #(
                .DIR_RESET(DIR_RESETS[8*g+7:8*g]),
                .KEEP_ON_SOFT((`KEEP_LATCH_ON_SOFT >> g) & 1)
            ) u_bank (
                .clk(clk),
                .sys_rst(sys_rst),
                .soft_rst(soft_rst),
                .wr_latch(wr_latch[g]),
                .wr_dir(wr_dir[g]),
                .wr_data(bank_wdata),
                .latch(latch_all[8*g+7:8*g]),
                .direction(dir_all[8*g+7:8*g])
            );
        end
    endgenerate

    wire [7:0] latch_b = latch_all[8*`BANK_B+7:8*`BANK_B];
    wire [7:0] latch_c = latch_all[8*`BANK_C+7:8*`BANK_C];
    wire [7:0] latch_d = latch_all[8*`BANK_D+7:8*`BANK_D];
    wire [7:0] dir_b = dir_all[8*`BANK_B+7:8*`BANK_B];
    wire [7:0] dir_c = dir_all[8*`BANK_C+7:8*`BANK_C];
    wire [7:0] dir_d = dir_all[8*`BANK_D+7:8*`BANK_D];
    wire [7:0] dir_e = dir_all[8*`BANK_E+7:8*`BANK_E];

    // ***************************************************************
    // option and segment enable registers
    // ***************************************************************
    reg [7:0] core_options; // top bit disables the general port pull-ups
    reg [7:0] lcd_segment_enable; // one bit per lcd pin group

    // both come back to all ones on every reset
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_options <= `RST_CORE_OPTIONS;
        end else if (soft_rst) begin
            core_options <= `RST_CORE_OPTIONS;
        end else if (wr_options) begin
            core_options <= reg_wdata;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lcd_segment_enable <= `RST_LCD_SEGMENT_ENABLE;
        end else if (soft_rst) begin
            lcd_segment_enable <= `RST_LCD_SEGMENT_ENABLE;
        end else if (wr_seg_enable) begin
            lcd_segment_enable <= reg_wdata;
        end
    end

    // ***************************************************************
    // general eight bit port
    // ***************************************************************
    // clear direction drives latch
    assign pin_b_oe = ~dir_b;
    assign pin_b_out = latch_b;
    // pull-ups only on inputs, and only while the disable bit is low;
    // the option reset value keeps them off after power-on
    assign pullup_on = dir_b & {8{~core_options[`BIT_PULLUP_DISABLE_N]}};

    // ***************************************************************
    // serial shared six bit port
    // ***************************************************************
    reg [5:0] c_oe; // resolved enable after peripheral overrides
    reg [5:0] c_out; // resolved output level

    // start from the direction register and let each enabled unit take
    // its pin; the stored direction bits are never changed by this, which
    // is why a bit operation on them reads back the software value
    always @* begin
        c_oe = ~dir_c[5:0];
        c_out = latch_c[5:0];
        if (secondary_osc_enable) begin
            c_oe[0] = 1'b1;
            c_out[0] = secondary_osc_out;
            // the crystal input pin must float
            c_oe[1] = 1'b0;
        end else if (secondary_timer_ext_clk_enable) begin
            c_oe[0] = 1'b0;
        end
        if (ccp_enable) begin
            // compare and pwm drive, capture listens
            c_oe[2] = ccp_output_mode;
            c_out[2] = capture_compare_pwm_pin;
        end
        if (serial_enable) begin
            if (serial_i2c_mode) begin
                c_oe[3] = i2c_scl_drive_low;
                c_out[3] = 1'b0;
                c_oe[4] = i2c_sda_drive_low;
                c_out[4] = 1'b0;
            end else begin
                c_oe[3] = serial_clk_master;
                c_out[3] = serial_clk_out;
                c_oe[4] = 1'b0;
                c_oe[5] = 1'b1;
                c_out[5] = serial_data_out;
            end
        end
    end

    assign pin_c_oe = c_oe;
    assign pin_c_out = c_out;
    // peripheral receive paths see the pin level at all times
    assign secondary_timer_clk_in = pin_c_in[0];
    assign secondary_osc_in = pin_c_in[1];
    assign capture_in = pin_c_in[2];
    assign serial_clk_in = pin_c_in[3];
    assign serial_data_in = pin_c_in[4];

    // ***************************************************************
    // lcd shared bidirectional port
    // ***************************************************************
    wire seg_lower = lcd_segment_enable[`SEG_ENABLE_LOWER_GROUP];
    wire seg_upper = lcd_segment_enable[`SEG_ENABLE_UPPER_GROUP];

    assign lcd_mode_d = {{3{seg_upper}}, {5{seg_lower}}};
    assign pin_d_oe = ~dir_d[4:0] & {5{~seg_lower}};
    assign pin_d_out = latch_d[4:0];
    assign lcd_common_driver_one = seg_upper;

    // ***************************************************************
    // lcd shared input port
    // ***************************************************************
    // input only, no drivers
    // its direction register is stored and read back but drives nothing
    assign lcd_mode_e = {lcd_segment_enable[`SEG_ENABLE_E_TOP],
                         {3{lcd_segment_enable[`SEG_ENABLE_E_MID]}},
                         {4{lcd_segment_enable[`SEG_ENABLE_E_LOW]}}};

    // ***************************************************************
    // read multiplexer
    // ***************************************************************
    reg [7:0] next_rdata; // value to present in the cycle after a read

    // pins handed to the lcd driver read as zero, so a stray segment
    // waveform never leaks into software reads
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `OFS_PORT_B_PINS: begin
                next_rdata = pin_b_in;
            end
            `OFS_SERIAL_SHARED_PORT: begin
                next_rdata = {2'b00, pin_c_in};
            end
            `OFS_LCD_SHARED_BIDIR_PORT: begin
                next_rdata = pin_d_in & ~lcd_mode_d;
            end
            `OFS_LCD_SHARED_INPUT_PORT: begin
                next_rdata = pin_e_in & ~lcd_mode_e;
            end
            `OFS_CORE_OPTIONS: begin
                next_rdata = core_options;
            end
            `OFS_PORT_B_DIRECTION: begin
                next_rdata = dir_b;
            end
            `OFS_SERIAL_SHARED_PORT_DIRECTION: begin
                next_rdata = dir_c & `SERIAL_PORT_MASK;
            end
            `OFS_LCD_SHARED_BIDIR_DIRECTION: begin
                next_rdata = dir_d;
            end
            `OFS_LCD_SHARED_INPUT_DIRECTION: begin
                next_rdata = dir_e;
            end
            `OFS_LCD_SEGMENT_ENABLE: begin
                next_rdata = lcd_segment_enable;
            end
            default: begin
                // unmapped addresses read as zero
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data stand for exactly the cycle after the strobe
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// >>> dv/gpio_lcd_asserts.sv
// concurrent checks on the ports of the lcd shared pin block
// assumes one clock domain and the offsets of the shared header
`timescale 1ns/1ps
`default_nettype none
`include "gpio_lcd_regs.vh"
module gpio_lcd_checker (
    // clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    // register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [7:0] pin_b_in,
    input wire logic [7:0] pin_b_out,
    input wire logic [7:0] pin_b_oe,
    input wire logic [5:0] pin_c_out,
    input wire logic [5:0] pin_c_oe,
    input wire logic ccp_enable,
    input wire logic ccp_output_mode,
    input wire logic serial_enable,
    input wire logic serial_i2c_mode,
    input wire logic serial_data_out,
    input wire logic [4:0] pin_d_oe,
    input wire logic [7:0] lcd_mode_d,
    input wire logic lcd_common_driver_one
);
    // ****************************************
    // register port steps
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // writes during soft reset are lost, so they are left out here
    sequence b_latch_write;
        reg_wr && reg_addr == `OFS_PORT_B_PINS && !soft_rst;
    endsequence
    sequence b_dir_write;
        reg_wr && reg_addr == `OFS_PORT_B_DIRECTION && !soft_rst;
    endsequence
    sequence b_pin_read;
        reg_rd && reg_addr == `OFS_PORT_B_PINS;
    endsequence
    latch_write_a:
        assert property (b_latch_write |=> pin_b_out == $past(reg_wdata))
        else $error("port b latch missed a write");
    dir_drive_a:
        assert property (b_dir_write |=> pin_b_oe == ~$past(reg_wdata))
        else $error("port b drive enables wrong after direction write");
    pin_read_a:
        assert property (b_pin_read |=> reg_rdata == $past(pin_b_in))
        else $error("port b read did not return the pin levels");
    rdata_idle_a:
        assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");
    upper_zero_a:
        assert property (reg_rd && (reg_addr == `OFS_SERIAL_SHARED_PORT
            || reg_addr == `OFS_SERIAL_SHARED_PORT_DIRECTION) |=> reg_rdata[7:6] == 2'h0)
        else $error("serial port upper bits not zero");
    // ****************************************
    // pin ownership
    // ****************************************
    common_group_a:
        assert property (lcd_mode_d[7:5] == {3{lcd_common_driver_one}})
        else $error("upper lcd group split");
    lcd_override_a:
        assert property (lcd_mode_d[0] |-> pin_d_oe == 5'h00)
        else $error("lcd port driven while lcd owns it");
    poweron_lcd_a:
        assert property ($fell(sys_rst) |-> lcd_mode_d == 8'hFF && pin_b_oe == 8'h00)
        else $error("power-on state wrong");
    soft_keep_a:
        assert property (soft_rst |=> $stable(pin_b_out) && pin_b_oe == 8'h00)
        else $error("soft reset lost port b latch or kept drives");
    ccp_dir_a:
        assert property (ccp_enable |-> pin_c_oe[2] == ccp_output_mode)
        else $error("capture pin direction not forced");
    spi_out_a:
        assert property (serial_enable && !serial_i2c_mode |-> pin_c_oe[5]
            && pin_c_out[5] == serial_data_out)
        else $error("serial data out not on bit 5");
endmodule
bind gpio_ports_lcd_shared gpio_lcd_checker u_chk (.clk, .sys_rst, .soft_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_b_in, .pin_b_out, .pin_b_oe, .pin_c_out,
    .pin_c_oe, .ccp_enable, .ccp_output_mode, .serial_enable, .serial_i2c_mode,
    .serial_data_out, .pin_d_oe, .lcd_mode_d, .lcd_common_driver_one);
`default_nettype wire

// >>> dv/gpio_ports_lcd_shared_tb_top.sv
// self-checking bench for the lcd shared pin ports
// assumes the design and its checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "gpio_lcd_regs.vh"
module gpio_ports_lcd_shared_tb_top;
    logic clk, sys_rst, soft_rst, reg_wr, reg_rd, probe, rd_d1;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_b_in, pin_b_out, pin_b_oe, pullup_on;
    logic [5:0] pin_c_in, pin_c_out, pin_c_oe;
    logic secondary_osc_enable, secondary_osc_out, secondary_timer_ext_clk_enable;
    logic secondary_timer_clk_in, secondary_osc_in, ccp_enable, ccp_output_mode;
    logic capture_compare_pwm_pin, capture_in, serial_enable, serial_i2c_mode;
    logic serial_clk_master, serial_clk_out, serial_data_out, i2c_scl_drive_low;
    logic i2c_sda_drive_low, serial_clk_in, serial_data_in, lcd_common_driver_one;
    logic [7:0] pin_d_in, pin_e_in, lcd_mode_d, lcd_mode_e;
    logic [4:0] pin_d_out, pin_d_oe;
    // expected results, oldest first; kind 0 is read data, others a pin vector
    typedef struct {int kind; logic [7:0] exp;} note_t;
    note_t notes[$];
    note_t n;
    int err_count, tests_run, m, i;
    logic [31:0] seed;
    logic [7:0] v, lb, ld, dc, lc, pd, pe, ed, ee, eoe, eout;

    gpio_ports_lcd_shared DUT (.clk, .sys_rst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pin_b_in, .pin_b_out, .pin_b_oe, .pullup_on, .pin_c_in,
        .pin_c_out, .pin_c_oe, .secondary_osc_enable, .secondary_osc_out,
        .secondary_timer_ext_clk_enable, .secondary_timer_clk_in, .secondary_osc_in,
        .ccp_enable, .ccp_output_mode, .capture_compare_pwm_pin, .capture_in,
        .serial_enable, .serial_i2c_mode, .serial_clk_master, .serial_clk_out,
        .serial_data_out, .i2c_scl_drive_low, .i2c_sda_drive_low, .serial_clk_in,
        .serial_data_in, .pin_d_in, .pin_d_out, .pin_d_oe, .pin_e_in, .lcd_mode_d,
        .lcd_mode_e, .lcd_common_driver_one);
    // ****************************************
    // helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] rnd8();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // kind 4 keeps only driven bits: an undriven pin's latch value is of no concern
    function automatic logic [7:0] pick(input int k);
        case (k)
            0: return reg_rdata;
            1: return pin_b_out;
            2: return pin_b_oe;
            3: return {2'h0, pin_c_oe};
            4: return {2'h0, pin_c_out & pin_c_oe};
            5: return {3'h0, pin_d_oe};
            6: return lcd_mode_d;
            7: return lcd_mode_e;
            8: return pullup_on;
            9: return {3'h0, pin_d_out};
            10: return {3'h0, serial_data_in, serial_clk_in, capture_in, secondary_osc_in,
                secondary_timer_clk_in};
            default: return {7'h00, lcd_common_driver_one};
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        notes.push_back('{0, e});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic pin(input int k, input logic [7:0] e);
        @(posedge clk);
        probe <= 1'b1;
        notes.push_back('{k, e});
        @(posedge clk);
        probe <= 1'b0;
    endtask
    task automatic complete_run();
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************
    // monitor: read data stand one cycle, so look mid-cycle
    // ****************************************
    always @(posedge clk) rd_d1 <= reg_rd;
    always @(negedge clk) begin
        if (rd_d1 === 1'b1 || probe === 1'b1) begin
            if (notes.size() == 0) begin
                err_count++;
                $display("ERROR at %0t: result without expectation", $time);
            end else begin
                n = notes.pop_front();
                check(pick(n.kind), n.exp);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("ERROR at %0t: run hung", $time);
        complete_run();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        {soft_rst, reg_wr, reg_rd, probe} = 4'h0;
        {reg_addr, reg_wdata, pin_c_in} = 23'h000000;
        {pin_b_in, pin_d_in, pin_e_in} = 24'h000000;
        {secondary_osc_enable, secondary_osc_out, secondary_timer_ext_clk_enable, ccp_enable,
            ccp_output_mode, capture_compare_pwm_pin, serial_enable, serial_i2c_mode,
            serial_clk_master, serial_clk_out, serial_data_out, i2c_scl_drive_low,
            i2c_sda_drive_low} = 13'h0000;
        seed = 32'h0001134A;
        err_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values, then the pins they steer
        rd(`OFS_PORT_B_DIRECTION, 8'hFF);
        rd(`OFS_SERIAL_SHARED_PORT_DIRECTION, 8'h3F);
        rd(`OFS_LCD_SHARED_BIDIR_DIRECTION, 8'hFF);
        rd(`OFS_CORE_OPTIONS, 8'hFF);
        rd(`OFS_LCD_SEGMENT_ENABLE, 8'hFF);
        pin(6, 8'hFF);
        pin(7, 8'hFF);
        pin(8, 8'h00);
        // general port: latch, drive enables, pull-ups on inputs only
        lb = rnd8();
        v = rnd8();
        wr(`OFS_PORT_B_PINS, lb);
        wr(`OFS_PORT_B_DIRECTION, v);
        pin(1, lb);
        pin(2, ~v);
        wr(`OFS_CORE_OPTIONS, 8'h7F);
        pin(8, v);
        pd = rnd8();
        pin_b_in <= pd;
        rd(`OFS_PORT_B_PINS, pd);
        // serial shared port, then each peripheral override in turn
        lc = rnd8();
        dc = rnd8();
        wr(`OFS_SERIAL_SHARED_PORT, lc);
        wr(`OFS_SERIAL_SHARED_PORT_DIRECTION, dc);
        rd(`OFS_SERIAL_SHARED_PORT_DIRECTION, dc & 8'h3F);
        pin_c_in <= pd[5:0];
        rd(`OFS_SERIAL_SHARED_PORT, {2'h0, pd[5:0]});
        pin(10, {3'h0, pd[4:0]});
        for (m = 0; m < 6; m++) begin
            v = rnd8();
            @(posedge clk);
            secondary_osc_enable <= (m == 0);
            secondary_timer_ext_clk_enable <= (m == 1);
            ccp_enable <= (m == 2);
            serial_enable <= (m == 3) || (m == 4);
            serial_i2c_mode <= (m == 4);
            {secondary_osc_out, ccp_output_mode, capture_compare_pwm_pin, serial_clk_master,
                serial_clk_out, serial_data_out, i2c_scl_drive_low, i2c_sda_drive_low} <= v;
            eoe = ~dc & 8'h3F;
            eout = lc;
            case (m)
                0: {eoe[1:0], eout[0]} = {2'b01, v[7]};
                1: eoe[0] = 1'b0;
                2: {eoe[2], eout[2]} = v[6:5];
                3: {eoe[5:3], eout[5], eout[3]} = {2'b10, v[4], v[2], v[3]};
                4: {eoe[4:3], eout[4:3]} = {v[0], v[1], 2'b00};
                default: eoe = eoe;
            endcase
            pin(3, eoe);
            pin(4, eout & eoe);
        end
        rd(`OFS_SERIAL_SHARED_PORT_DIRECTION, dc & 8'h3F);
        // walk each segment enable bit over the lcd shared ports
        pd = rnd8();
        pe = rnd8();
        ld = rnd8();
        pin_d_in <= pd;
        pin_e_in <= pe;
        wr(`OFS_LCD_SHARED_BIDIR_DIRECTION, 8'h00);
        wr(`OFS_LCD_SHARED_BIDIR_PORT, ld);
        for (i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            ed = {{3{v[7]}}, {5{v[0]}}};
            ee = {v[6], {3{v[2]}}, {4{v[1]}}};
            wr(`OFS_LCD_SEGMENT_ENABLE, v);
            pin(6, ed);
            pin(7, ee);
            pin(11, {7'h00, v[7]});
            pin(5, {3'h0, {5{~v[0]}}});
            rd(`OFS_LCD_SHARED_BIDIR_PORT, pd & ~ed);
            rd(`OFS_LCD_SHARED_INPUT_PORT, pe & ~ee);
        end
        pin(9, {3'h0, ld[4:0]});
        v = rnd8();
        wr(`OFS_LCD_SHARED_BIDIR_DIRECTION, v);
        pin(5, {3'h0, ~v[4:0]});
        // unmapped place reads zero
        wr(9'h0AA, 8'h5A);
        rd(9'h0AA, 8'h00);
        // other reset keeps general latches, clears lcd latch
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        pin(1, lb);
        pin(2, 8'h00);
        pin(4, lc & 8'h00);
        pin(9, 8'h00);
        pin(6, 8'hFF);
        rd(`OFS_SERIAL_SHARED_PORT_DIRECTION, 8'h3F);
        // power-on reset in mid-run
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        pin(1, 8'h00);
        pin(7, 8'hFF);
        repeat (4) @(posedge clk);
        if (notes.size() != 0) begin
            err_count++;
            $display("ERROR at %0t: results missing", $time);
        end
        complete_run();
    end
endmodule
`default_nettype wire
